//--- rtl/ebg_params.svh
// Purpose: constants of the external bus grant handshake
// Assumes: processor cycle equals one sys_clk_in period
// Notes: definitions only
`ifndef EBG_PARAMS_SVH
`define EBG_PARAMS_SVH
`define EBG_CLK_NS 50
`define EBG_PROC_PER_IN 2
`define EBG_LOCK_IN_CYCLES 2000
`define EBG_RESET_MIN_CYCLES 5
`define EBG_SEL_W 5
`define EBG_SYNC_STAGES 2
`endif

//--- rtl/ebg_pkg.sv
// Purpose: types of the external bus grant handshake
// Assumes: nothing
// Notes: grant state machine states
package ebg_pkg;
    typedef enum logic [1:0] {
        EBG_OWN,
        EBG_RELEASE,
        EBG_GRANTED,
        EBG_RETURN
    } ebg_state_e;
endpackage : ebg_pkg

//--- rtl/ebg_sync.sv
// Purpose: two flip-flop synchroniser for asynchronous pins
// Assumes: inputs are levels
// Notes: first stage is read only by the second
`timescale 1ns/1ps
`default_nettype none
module ebg_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta;

    // meta stage feeds only the output stage
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            meta <= INIT;
            sync_out <= INIT;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end
endmodule : ebg_sync
`default_nettype wire

//--- rtl/ebg_grant.sv
// Purpose: hands the external memory bus to an outside master
// Assumes: sys_clk_in is the processor clock, the doubled input clock, 20 MHz
// Notes: strobes are released a full cycle before grant and regained a cycle after
`timescale 1ns/1ps
`default_nettype none
`include "ebg_params.svh"

// Contract
// - One processor cycle lasts half an input clock period, so input rises come every two cycles.
// - The clock multiplier reaches lock within 2000 stable input clock cycles.
// - The bus request pin is asynchronous and is synchronised before use.
// - A request is recognised in the current cycle when timing is met, else in the next; here the two synchroniser stages delay it by two more cycles.
// - All selects and read and write strobes float before the grant goes low.
// - Selects and strobes are driven again only after the grant has returned high.
// - While granted and the core needs the bus, the hung-grant indicator is low.
// - Selects and strobes already float before the hung-grant indicator goes low.
// - Selects and strobes are re-enabled only after the hung-grant indicator is high again.
module ebg_grant
    import ebg_pkg::*;
#(
    parameter int LOCK_CYCLES = `EBG_LOCK_IN_CYCLES,
    parameter int RESET_MIN = `EBG_RESET_MIN_CYCLES
) (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic input_clock_pin_in,
    input wire logic reset_pin_n_in,
    input wire logic bus_request_n_in,
    input wire logic core_needs_bus_in,
    input wire logic [`EBG_SEL_W-1:0] core_selects_n_in,
    input wire logic core_rd_n_in,
    input wire logic core_wr_n_in,
    output logic [`EBG_SEL_W-1:0] memory_space_selects_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic strobe_oe_out,
    output logic bus_grant_n_out,
    output logic grant_hung_n_out,
    output logic clock_locked_out,
    output logic in_reset_out
);
    // ****************************************
    // pin synchronisation
    // ****************************************
    logic [2:0] pins_sync;

    // all three pins are asynchronous to the processor clock
    ebg_sync #(.WIDTH(3), .INIT(3'h6)) ebg_sync_i (
        .sys_clk_in(sys_clk_in),
        .resetn_in(resetn_in),
        .async_in({reset_pin_n_in, bus_request_n_in, input_clock_pin_in}),
        .sync_out(pins_sync)
    );

    wire pin_clk_s = pins_sync[0];
    wire req_s = ~pins_sync[1];
    wire rst_pin_low = ~pins_sync[2];

    // ****************************************
    // clock ratio and lock
    // ****************************************
    logic pin_clk_d;
    logic [1:0] period_cnt;
    logic [11:0] lock_cnt;
    wire pin_clk_rise = pin_clk_s & ~pin_clk_d;
    // an input rise must follow the last by exactly two processor cycles
    wire ratio_ok = (period_cnt == 2'(`EBG_PROC_PER_IN));
    wire lock_done = (lock_cnt == 12'(LOCK_CYCLES));
    wire [1:0] next_period = (period_cnt == 2'h3) ? 2'h3 : period_cnt + 2'h1;

    // count processor cycles per input period; a bad period restarts lock
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_clk_d <= 1'b0;
            period_cnt <= 2'h0;
            lock_cnt <= 12'h000;
        end else begin
            pin_clk_d <= pin_clk_s;
            period_cnt <= pin_clk_rise ? 2'h1 : next_period;
            if (pin_clk_rise && !ratio_ok)
                lock_cnt <= 12'h000;
            else if (pin_clk_rise && !lock_done)
                lock_cnt <= lock_cnt + 12'h001;
        end
    end

    // lock flag rises once the count of good input cycles is reached
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clock_locked_out <= 1'b0;
        end else begin
            clock_locked_out <= lock_done;
        end
    end

    // ****************************************
    // reset pin qualification
    // ****************************************
    logic [2:0] low_cnt;
    wire reset_valid = (low_cnt == 3'(RESET_MIN));

    // shorter low pulses are treated as glitches, not resets
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            low_cnt <= 3'h0;
            in_reset_out <= 1'b0;
        end else begin
            if (!rst_pin_low)
                low_cnt <= 3'h0;
            else if (!reset_valid)
                low_cnt <= low_cnt + 3'h1;
            if (reset_valid)
                in_reset_out <= 1'b1;
            else if (!rst_pin_low)
                in_reset_out <= 1'b0;
        end
    end

    // ****************************************
    // grant state machine
    // ****************************************
    ebg_state_e state;
    ebg_state_e next_state;
    wire halt = in_reset_out | ~clock_locked_out;

    // release to grant and ungrant to re-enable one cycle apart; the grant holds until the request drops
    always_comb begin
        next_state = state;
        unique case (state)
            EBG_OWN: if (req_s && !halt) next_state = EBG_RELEASE;
            EBG_RELEASE: next_state = req_s ? EBG_GRANTED : EBG_RETURN;
            EBG_GRANTED: if (!req_s) next_state = EBG_RETURN;
            EBG_RETURN: next_state = EBG_OWN;
        endcase
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            state <= EBG_OWN;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // pin drivers
    // ****************************************
    // oe, grant and hung-grant registered from the next state so they change on the same edge as the state
    wire next_oe = (next_state == EBG_OWN) && !in_reset_out;
    wire next_grant_n = (next_state != EBG_GRANTED);
    wire next_hung_n = !((next_state == EBG_GRANTED) && core_needs_bus_in);

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            strobe_oe_out <= 1'b0;
            bus_grant_n_out <= 1'b1;
            grant_hung_n_out <= 1'b1;
        end else begin
            strobe_oe_out <= next_oe;
            bus_grant_n_out <= next_grant_n;
            grant_hung_n_out <= next_hung_n;
        end
    end

    // strobe values park inactive high while not driven
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            memory_space_selects_out <= '1;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
        end else begin
            memory_space_selects_out <= next_oe ? core_selects_n_in : '1;
            rd_n_out <= next_oe ? core_rd_n_in : 1'b1;
            wr_n_out <= next_oe ? core_wr_n_in : 1'b1;
        end
    end

    // ****************************************
    // assertions
    // ****************************************
    ratio_check_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        pin_clk_rise && !ratio_ok |=> lock_cnt == 12'h000)
        else $error("lock not restarted after bad input period");
    lock_count_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        lock_done |=> clock_locked_out)
        else $error("lock flag late");
    req_sync_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        state == EBG_OWN && $rose(req_s) && !halt |=> state == EBG_RELEASE)
        else $error("request not taken");
    req_latency_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        state == EBG_OWN && req_s && !halt |=> ##1 !bus_grant_n_out || !req_s)
        else $error("grant not given two cycles after request");
    float_first_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $fell(bus_grant_n_out) |-> !strobe_oe_out && $past(!strobe_oe_out))
        else $error("grant before strobes floated");
    drive_after_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $rose(strobe_oe_out) |-> bus_grant_n_out && $past(bus_grant_n_out))
        else $error("strobes driven before grant high");
    hung_grant_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !grant_hung_n_out |-> !bus_grant_n_out)
        else $error("hung indicator without grant");
    hung_float_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $fell(grant_hung_n_out) |-> !strobe_oe_out && $past(!strobe_oe_out))
        else $error("hung indicator before strobes floated");
    hung_release_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        $rose(strobe_oe_out) |-> $past(grant_hung_n_out))
        else $error("strobes driven before hung indicator high");
    grant_hold_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !bus_grant_n_out && !req_s |=> bus_grant_n_out ##1 strobe_oe_out || in_reset_out)
        else $error("grant not dropped and bus not regained");
    // the strobes stay floated for the whole borrow, not only around its edges
    grant_float_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        !bus_grant_n_out |-> !strobe_oe_out)
        else $error("strobes driven while bus granted away");
    hung_need_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        grant_hung_n_out == !(!bus_grant_n_out && $past(core_needs_bus_in)))
        else $error("hung indicator does not follow core bus need");
    // a pending request waits out reset and lock, so no borrow starts while halted
    refuse_halt_a: assert property (@(posedge sys_clk_in) disable iff (!resetn_in)
        halt && state == EBG_OWN |=> state == EBG_OWN)
        else $error("request taken while halted");
endmodule : ebg_grant
`default_nettype wire

//--- tb/ebg_master_model.sv
// Purpose: outside bus master that borrows the external memory bus
// Assumes: go_in is a one-cycle pulse
// Notes: request is held until hold_in cycles have passed and grant is seen
`timescale 1ns/1ps
`default_nettype none
module ebg_master_model (
    input wire logic sys_clk_in,
    input wire logic resetn_in,
    input wire logic go_in,
    input wire logic [7:0] hold_in,
    input wire logic bus_grant_n_in,
    output logic bus_request_n_out
);
    logic [7:0] count;
    // never drops the request before grant, so no borrow is abandoned halfway
    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            bus_request_n_out <= 1'b1;
            count <= 8'h00;
        end else if (go_in && bus_request_n_out) begin
            bus_request_n_out <= 1'b0;
            count <= 8'h00;
        end else if (!bus_request_n_out) begin
            count <= count + 8'h01;
            if (!bus_grant_n_in && count >= hold_in) bus_request_n_out <= 1'b1;
        end
    end
endmodule : ebg_master_model
`default_nettype wire

//--- tb/ebg_grant_test.sv
// Purpose: self-checking bench for the bus grant handshake
// Assumes: lock count shortened to 4 input clock rises
// Notes: outputs are sampled on the falling edge, inputs driven on the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "ebg_params.svh"
module ebg_grant_test;
    logic clk, rst_n, in_clk, clk_en, rst_pin_n, needs, go;
    logic [4:0] sel_c, sel;
    logic rd_n, wr_n, oe, grant_n, hung_n, locked, in_rst, req_n;
    int n_errors = 0;
    int check_count = 0;
    ebg_grant #(.LOCK_CYCLES(4), .RESET_MIN(`EBG_RESET_MIN_CYCLES)) ebg_grant_i (
        .sys_clk_in(clk), .resetn_in(rst_n), .input_clock_pin_in(in_clk),
        .reset_pin_n_in(rst_pin_n), .bus_request_n_in(req_n), .core_needs_bus_in(needs),
        .core_selects_n_in(sel_c), .core_rd_n_in(sel_c[0]), .core_wr_n_in(sel_c[1]),
        .memory_space_selects_out(sel), .rd_n_out(rd_n), .wr_n_out(wr_n),
        .strobe_oe_out(oe), .bus_grant_n_out(grant_n), .grant_hung_n_out(hung_n),
        .clock_locked_out(locked), .in_reset_out(in_rst));
    ebg_master_model ebg_master_model_i (.sys_clk_in(clk), .resetn_in(rst_n), .go_in(go),
        .hold_in(8'h0c), .bus_grant_n_in(grant_n), .bus_request_n_out(req_n));
    // ****************************************
    // clocks: input pin rises every two cycles
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) if (clk_en) in_clk <= ~in_clk;
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check
    task automatic test_done;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : test_done
    // counts falling edges until grant (or request) shows v; po is oe one sample earlier
    task automatic wait_on(input logic on_req, input logic v, output int n, output logic po);
        n = 0;
        po = oe;
        while ((on_req ? req_n : grant_n) !== v) begin
            po = oe;
            @(negedge clk);
            n++;
            if (n > 60) begin
                n_errors++;
                test_done();
            end
        end
    endtask : wait_on
    // a request before lock stays pending, then is served once locked
    task automatic t_lock;
        int n;
        logic po;
        @(posedge clk) go <= 1'b1;
        @(posedge clk) go <= 1'b0;
        repeat (12) @(negedge clk);
        check(grant_n, 1'b1);
        @(posedge clk) clk_en <= 1'b1;
        n = 0;
        while (locked !== 1'b1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(locked, 1'b1);
        if (locked !== 1'b1) test_done();
        wait_on(1'b0, 1'b0, n, po);
        wait_on(1'b0, 1'b1, n, po);
        $display("test lock done");
    endtask : t_lock
    // full borrow with exact latencies and strobe float around grant and hung-grant
    task automatic t_grant(input logic need);
        int n;
        logic po;
        @(posedge clk) begin
            needs <= need;
            go <= 1'b1;
        end
        @(posedge clk) go <= 1'b0;
        @(negedge clk);
        wait_on(1'b0, 1'b0, n, po);
        check(n, `EBG_SYNC_STAGES + 2);
        check(po, 1'b0);
        check(sel, 5'h1f);
        check(hung_n, !need);
        wait_on(1'b1, 1'b1, n, po);
        check(grant_n, 1'b0);
        wait_on(1'b0, 1'b1, n, po);
        check(n, `EBG_SYNC_STAGES + 1);
        check(oe, 1'b0);
        check(hung_n, 1'b1);
        @(negedge clk);
        check(oe, 1'b1);
        check({sel, rd_n, wr_n}, {sel_c, sel_c[0], sel_c[1]});
        $display("test grant done");
    endtask : t_grant
    // a short reset pulse is ignored, a long one is taken
    task automatic t_reset_pin(input int len, input logic exp);
        @(posedge clk) rst_pin_n <= 1'b0;
        repeat (len - 1) @(posedge clk);
        rst_pin_n <= 1'b1;
        repeat (3) @(negedge clk);
        check({in_rst, oe}, {exp, ~exp});
        repeat (8) @(negedge clk);
        check({in_rst, oe}, 2'b01);
        $display("test reset pin done");
    endtask : t_reset_pin
    initial begin
        rst_n = 1'b0;
        in_clk = 1'b0;
        clk_en = 1'b0;
        rst_pin_n = 1'b1;
        needs = 1'b0;
        go = 1'b0;
        sel_c = 5'h15;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        @(negedge clk);
        t_lock();
        t_grant(1'b1);
        @(posedge clk) sel_c <= 5'h0a;
        t_grant(1'b0);
        t_reset_pin(2, 1'b0);
        t_reset_pin(`EBG_RESET_MIN_CYCLES + 3, 1'b1);
        test_done();
    end
endmodule : ebg_grant_test
`default_nettype wire
